// ==== sfe_pkg.sv ====
// constants and types shared by the serial flash pin front end
package sfe_pkg;

  // ===========================================================
  // framing
  localparam int          BYTE_BITS    = 8;
  localparam int          ADDR_BYTES   = 3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [1:0]  ADDR_LAST    = 2'h2;

  // ===========================================================
  // pin synchroniser lanes and their idle levels
  localparam int          PIN_COUNT    = 5;
  localparam int          PIN_CS_N     = 0;
  localparam int          PIN_SCK      = 1;
  localparam int          PIN_SI       = 2;
  localparam int          PIN_WP_N     = 3;
  localparam int          PIN_RESET_N  = 4;
  localparam logic [4:0]  PIN_IDLE     = 5'h19;

  // ===========================================================
  // internal power-on reset hold time
  localparam int          CLK_MHZ      = 100;
  localparam int          POR_NS       = 1000;
  localparam int          POR_CYCLES   = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  POR_LOAD     = 8'(POR_CYCLES);

  // ===========================================================
  // operation class reported by the command decoder
  typedef enum logic [1:0] {
    OPC_OTHER   = 2'b00,
    OPC_MODIFY  = 2'b01,
    OPC_SPR_WR  = 2'b10,
    OPC_PROTECT = 2'b11
  } sfe_class_type;

  // ===========================================================
  // frame states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_OPCODE  = 3'b001,
    ST_ADDR    = 3'b010,
    ST_DATA    = 3'b011,
    ST_DISCARD = 3'b100
  } sfe_state_type;

endpackage

// ==== sfe_pin_sync.sv ====
// two-flop synchroniser with edge detection for the pin inputs
`timescale 1ns/10ps
module sfe_pin_sync #(
  parameter int           WIDTH = 5,
  parameter logic [4:0]   INIT  = 5'h00
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // raw pins
  input  wire logic [WIDTH-1:0] din,
  // synchronised level and edges
  output logic      [WIDTH-1:0] lvl,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] prev;

  // ===========================================================
  // per lane: the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta[i]  <= INIT[i];
          stage[i] <= INIT[i];
          prev[i]  <= INIT[i];
        end else begin
          meta[i]  <= din[i];
          stage[i] <= meta[i];
          prev[i]  <= stage[i];
        end
      end
      assign lvl[i]  = stage[i];
      assign rise[i] = stage[i] & ~prev[i];
      assign fall[i] = ~stage[i] & prev[i];
    end
  endgenerate

endmodule

// ==== sfe_front_end.sv ====
// serial flash pin front end: framing, shifting, write protect and reset
`timescale 1ns/10ps
module sfe_front_end
  import sfe_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic        wp_n,
  input  wire logic        reset_n,
  output logic             so_out,
  output logic             so_oe_n,
  // command decoder side
  input  wire logic [1:0]  op_class,
  input  wire logic        busy,
  input  wire logic [7:0]  tx_byte,
  output logic [7:0]       rx_byte,
  output logic             opcode_valid,
  output logic             addr_valid,
  output logic             data_valid,
  output logic             tx_req,
  output logic             exec_pulse,
  output logic             abort_pulse,
  // status
  output logic             hw_protect,
  output logic             standby
);

  // ===========================================================
  // pin synchronisers
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  assign pins = {reset_n, wp_n, si, sck, cs_n};

  sfe_pin_sync #(
    .WIDTH (PIN_COUNT),
    .INIT  (PIN_IDLE)
  ) u_sync (
    .mclk  (mclk),
    .rst   (rst),
    .din   (pins),
    .lvl   (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // ===========================================================
  // decoded pin events
  wire cs_high   = pin_lvl[PIN_CS_N];
  wire cs_start  = pin_fall[PIN_CS_N];
  wire cs_end    = pin_rise[PIN_CS_N];
  wire wp_low    = ~pin_lvl[PIN_WP_N];
  wire sck_rise  = pin_rise[PIN_SCK] & ~cs_high;
  wire sck_fall  = pin_fall[PIN_SCK] & ~cs_high;
  wire si_bit    = pin_lvl[PIN_SI];
  wire rst_pin   = ~pin_lvl[PIN_RESET_N];

  // ===========================================================
  // internal power-on reset: holds the block idle after rst drops
  logic [7:0] por_count;
  wire        por_busy = (por_count != 8'h00);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      por_count <= POR_LOAD;
    end else if (por_busy) begin
      por_count <= por_count - 8'h01;
    end
  end

  // reset pin or power-on hold both force idle
  wire dev_rst = por_busy | rst_pin;

  // ===========================================================
  // frame state and receive shifter
  sfe_state_type state;
  sfe_state_type next_state;
  logic [2:0]    rx_count;
  logic [6:0]    rx_shift;
  logic [1:0]    addr_count;
  logic          discarded;

  wire       byte_done = sck_rise & (rx_count == BIT_LAST);
  wire [7:0] byte_in   = {rx_shift, si_bit};
  wire       cls_block = (op_class == OPC_MODIFY) | (op_class == OPC_SPR_WR);
  wire       refuse    = wp_low & cls_block;

  // next state on each completed byte
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:    next_state = ST_IDLE;
      ST_OPCODE:  next_state = refuse ? ST_DISCARD : ST_ADDR;
      ST_ADDR:    next_state = (addr_count == ADDR_LAST) ? ST_DATA : ST_ADDR;
      ST_DATA:    next_state = ST_DATA;
      ST_DISCARD: next_state = ST_DISCARD;
      default:    next_state = ST_IDLE;
    endcase
  end

  // frame sequencer: a deselect always returns to idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (dev_rst || cs_end || cs_high) begin
      state <= ST_IDLE;
    end else if (cs_start) begin
      state <= ST_OPCODE;
    end else if (byte_done) begin
      state <= next_state;
    end
  end

  // bit and address byte counters
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_count   <= 3'h0;
      rx_shift   <= 7'h00;
      addr_count <= 2'h0;
    end else if (dev_rst || cs_start || cs_high) begin
      rx_count   <= 3'h0;
      rx_shift   <= 7'h00;
      addr_count <= 2'h0;
    end else if (sck_rise) begin
      rx_count <= rx_count + 3'h1;
      rx_shift <= byte_in[6:0];
      if (byte_done && state == ST_ADDR) begin
        addr_count <= addr_count + 2'h1;
      end
    end
  end

  // discard flag marks a refused command until the next frame starts or a reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      discarded <= 1'b0;
    end else if (dev_rst || cs_start) begin
      discarded <= 1'b0;
    end else if (byte_done && state == ST_OPCODE && refuse) begin
      discarded <= 1'b1;
    end
  end

  // ===========================================================
  // receive strobes towards the decoder; discarded frames give only the opcode strobe
  wire take   = byte_done & ~dev_rst & ~cs_high;
  wire is_op  = take & (state == ST_OPCODE);
  wire is_adr = take & (state == ST_ADDR);
  wire is_dat = take & (state == ST_DATA);
  wire fin_ok = cs_end & ~dev_rst & (state != ST_IDLE) & ~discarded;
  wire abort  = dev_rst & (state != ST_IDLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_byte      <= 8'h00;
      opcode_valid <= 1'b0;
      addr_valid   <= 1'b0;
      data_valid   <= 1'b0;
      exec_pulse   <= 1'b0;
      abort_pulse  <= 1'b0;
    end else begin
      if (take) begin
        rx_byte <= byte_in;
      end
      opcode_valid <= is_op;
      addr_valid   <= is_adr;
      data_valid   <= is_dat;
      exec_pulse   <= fin_ok;
      abort_pulse  <= abort;
    end
  end

  // ===========================================================
  // transmit shifter: a new byte is fetched every eighth falling edge
  logic [2:0] tx_count;
  logic [6:0] tx_shift;
  wire        tx_load = sck_fall & (tx_count == 3'h0);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_count <= 3'h0;
      tx_shift <= 7'h00;
      so_out   <= 1'b0;
      tx_req   <= 1'b0;
    end else if (dev_rst || cs_high) begin
      tx_count <= 3'h0;
      tx_shift <= 7'h00;
      so_out   <= 1'b0;
      tx_req   <= 1'b0;
    end else begin
      tx_req <= tx_load;
      if (sck_fall) begin
        tx_count <= tx_count + 3'h1;
        if (tx_load) begin
          so_out   <= tx_byte[7];
          tx_shift <= tx_byte[6:0];
        end else begin
          so_out   <= tx_shift[6];
          tx_shift <= {tx_shift[5:0], 1'b0};
        end
      end
    end
  end

  // ===========================================================
  // pin enable and status: standby waits for self-timed work
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      so_oe_n    <= 1'b1;
      standby    <= 1'b0;
      hw_protect <= 1'b0;
    end else begin
      so_oe_n    <= cs_high | dev_rst;
      standby    <= cs_high & ~busy & ~dev_rst;
      hw_protect <= wp_low;
    end
  end

  // ===========================================================
  // checks
  chk_so_tristate: assert property (@(posedge mclk) disable iff (rst)
    cs_high |=> so_oe_n)
    else $error("serial output driven while deselected");

  chk_standby_busy: assert property (@(posedge mclk) disable iff (rst)
    busy |=> !standby)
    else $error("standby entered during self-timed cycle");

  chk_no_capture: assert property (@(posedge mclk) disable iff (rst)
    cs_high |=> !opcode_valid && !addr_valid && !data_valid)
    else $error("byte taken while deselected");

  chk_wp_discard: assert property (@(posedge mclk) disable iff (rst)
    is_op && refuse |=> discarded && state == ST_DISCARD ##1 !addr_valid)
    else $error("protected command not discarded");

  chk_protect_pass: assert property (@(posedge mclk) disable iff (rst)
    is_op && op_class == OPC_PROTECT |=> state == ST_ADDR)
    else $error("protect command refused");

  chk_reset_idle: assert property (@(posedge mclk) disable iff (rst)
    rst_pin |=> state == ST_IDLE && so_oe_n)
    else $error("reset pin did not force idle");

  chk_discard_exec: assert property (@(posedge mclk) disable iff (rst)
    exec_pulse |-> !$past(discarded))
    else $error("discarded frame executed");

  chk_msb_launch: assert property (@(posedge mclk) disable iff (rst)
    tx_load && !dev_rst |=> so_out == $past(tx_byte[7]))
    else $error("first launched bit is not the top bit");

  chk_bit_capture: assert property (@(posedge mclk) disable iff (rst)
    is_op |=> rx_byte[0] == $past(si_bit) && opcode_valid)
    else $error("opcode last bit not taken on rise");

  chk_por_hold: assert property (@(posedge mclk) disable iff (rst)
    por_busy |=> !opcode_valid && state == ST_IDLE)
    else $error("activity during power-on hold");

  // any reset source keeps the pin released and standby off
  chk_standby_reset: assert property (@(posedge mclk) disable iff (rst)
    dev_rst |=> !standby && so_oe_n)
    else $error("standby or output enable during reset");

  // the decoder must see a fetch request for every loaded byte
  chk_tx_request: assert property (@(posedge mclk) disable iff (rst)
    tx_load && !dev_rst |=> tx_req)
    else $error("byte loaded without fetch request");

  chk_exec_single: assert property (@(posedge mclk) disable iff (rst)
    exec_pulse |=> !exec_pulse)
    else $error("one frame executed twice");

  chk_abort_idle: assert property (@(posedge mclk) disable iff (rst)
    abort_pulse |-> state == ST_IDLE)
    else $error("abort left the frame running");

  cov_opcode: cover property (@(posedge mclk) disable iff (rst) opcode_valid);
  cov_discard: cover property (@(posedge mclk) disable iff (rst) discarded && cs_end);
  cov_data: cover property (@(posedge mclk) disable iff (rst) data_valid ##[1:200] exec_pulse);
  cov_abort: cover property (@(posedge mclk) disable iff (rst) abort_pulse);

endmodule

// ==== sfe_host_model.sv ====
// host master model that drives the serial pins of the front end
`timescale 1ns/10ps
module sfe_host_model (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  // ===========================================================
  // state of the pins; serial clock idles low, so mode 0 framing
  logic [15:0] miso;  // output bits seen at each rising serial clock
  // a released output has no pull: show it inverted so a missing enable stands out
  wire         so_line = so_oe_n ? ~so_out : so_out;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
    miso = 16'h0000;
  end

  // every pin change lands on a falling system clock edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // select the device; the falling edge opens the operation
  task automatic begin_frame();
    wait_cyc(1);
    cs_n = 1'b0;
    wait_cyc(8);
  endtask

  // one byte, msb first; data is set while the clock is low and held over the rise
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si = b[i];
      wait_cyc(8);
      sck  = 1'b1;
      miso = {miso[14:0], so_line};
      wait_cyc(8);
      sck = 1'b0;
    end
  endtask

  // deselect; the input line has no pull, so it is left at the inverse level
  task automatic end_frame();
    wait_cyc(8);
    cs_n = 1'b1;
    si   = ~si;
    wait_cyc(16);
  endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the serial flash pin front end
`timescale 1ns/10ps
module tb_top;
  import sfe_pkg::*;
  // ===========================================================
  // design hookup
  logic       mclk, rst, wp_n, reset_n, busy;
  logic [1:0] op_class;
  logic [7:0] tx_byte = 8'hb4;  // decoder model steps it on every fetch
  logic [7:0] rx_byte;
  logic       opcode_valid, addr_valid, data_valid, tx_req, exec_pulse, abort_pulse, hw_protect, standby;
  wire        cs_n, sck, si, so_out, so_oe_n;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         n_op = 0, n_ad = 0, n_da = 0, n_ex = 0, n_ab = 0, n_tx = 0;
  logic [7:0] rxq[$];
  logic       d1 = 1'b0, d2 = 1'b0;

  sfe_front_end uut (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .reset_n(reset_n), .so_out(so_out), .so_oe_n(so_oe_n), .op_class(op_class), .busy(busy),
    .tx_byte(tx_byte), .rx_byte(rx_byte), .opcode_valid(opcode_valid), .addr_valid(addr_valid),
    .data_valid(data_valid), .tx_req(tx_req), .exec_pulse(exec_pulse), .abort_pulse(abort_pulse),
    .hw_protect(hw_protect), .standby(standby));
  sfe_host_model host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe_n(so_oe_n));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ===========================================================
  // strobe counters; bytes are picked up two cycles late, rx_byte holds far longer
  always @(posedge mclk) begin
    if (opcode_valid === 1'b1) n_op++;
    if (addr_valid === 1'b1) n_ad++;
    if (data_valid === 1'b1) n_da++;
    if (exec_pulse === 1'b1) n_ex++;
    if (abort_pulse === 1'b1) n_ab++;
    if (tx_req === 1'b1) begin
      n_tx++;
      tx_byte <= tx_byte + 8'h11;
    end
    d1 <= (opcode_valid === 1'b1) || (addr_valid === 1'b1) || (data_valid === 1'b1);
    d2 <= d1;
    if (d2) rxq.push_back(rx_byte);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ===========================================================
  // scenarios
  task automatic t_power();
    host.wait_cyc(50);
    check(standby, 1'b0);
    check(so_oe_n, 1'b1);
    host.wait_cyc(60);
    check(standby, 1'b1);
    check(so_oe_n, 1'b1);
    $display("test power done");
  endtask

  // full frame: opcode, three address bytes, one data byte, output stream
  task automatic t_frame();
    int o = n_op, a = n_ad, d = n_da, e = n_ex, t = n_tx;
    logic [7:0] exp_q[$] = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h9e};
    op_class = 2'h1;
    rxq.delete();
    host.begin_frame();
    check(standby, 1'b0);
    check(so_oe_n, 1'b0);
    foreach (exp_q[i]) begin
      host.xfer(exp_q[i]);
      if (i == 1) check(host.miso[14:7], 8'hb4);
      if (i == 2) check(host.miso[14:7], 8'hc5);
    end
    host.end_frame();
    check(n_tx - t, 5);
    check(n_op - o, 1);
    check(n_ad - a, 3);
    check(n_da - d, 1);
    check(n_ex - e, 1);
    check(rxq.size(), 5);
    foreach (rxq[i]) check(rxq[i], exp_q[i]);
    check(so_oe_n, 1'b1);
    check(standby, 1'b1);
    $display("test frame done");
  endtask

  // clocking bits while deselected
  task automatic t_deselect();
    int o = n_op, e = n_ex, t = n_tx;
    host.xfer(8'h3c);
    check(n_op - o, 0);
    check(n_ex - e, 0);
    check(n_tx - t, 0);
    check(so_oe_n, 1'b1);
    $display("test deselect done");
  endtask

  // every opcode class with write protect asserted
  task automatic t_protect();
    int a, e;
    wp_n = 1'b0;
    host.wait_cyc(4);
    check(hw_protect, 1'b1);
    for (int c = 0; c < 4; c++) begin
      a = n_ad;
      e = n_ex;
      op_class = c[1:0];
      host.begin_frame();
      host.xfer(8'h81);
      repeat (3) host.xfer(8'h00);
      host.end_frame();
      check(n_ex - e, (c == 1 || c == 2) ? 0 : 1);
      check(n_ad - a, (c == 1 || c == 2) ? 0 : 3);
      check(standby, 1'b1);
    end
    wp_n = 1'b1;
    host.wait_cyc(4);
    check(hw_protect, 1'b0);
    $display("test protect done");
  endtask

  // self-timed cycle outlasts the frame
  task automatic t_busy();
    op_class = 2'h1;
    host.begin_frame();
    host.xfer(8'h82);
    busy = 1'b1;
    host.end_frame();
    check(standby, 1'b0);
    host.wait_cyc(1);
    busy = 1'b0;
    host.wait_cyc(4);
    check(standby, 1'b1);
    $display("test busy done");
  endtask

  // reset pin pulled low in mid-frame
  task automatic t_reset_pin();
    int b = n_ab, e = n_ex, o = n_op;
    op_class = 2'h0;
    host.begin_frame();
    host.xfer(8'h0b);
    reset_n = 1'b0;
    host.wait_cyc(8);
    check(n_ab - b, 1);
    host.xfer(8'h0b);
    check(n_op - o, 1);
    check(n_ab - b, 1);
    check(standby, 1'b0);
    reset_n = 1'b1;
    host.end_frame();
    check(n_ex - e, 0);
    check(standby, 1'b1);
    $display("test reset pin done");
  endtask

  // ===========================================================
  // main sequence and watchdog
  initial begin
    rst      = 1'b1;
    wp_n     = 1'b1;
    reset_n  = 1'b1;
    busy     = 1'b0;
    op_class = 2'h0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_power();
    t_frame();
    t_deselect();
    t_protect();
    t_busy();
    t_reset_pin();
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule
